// *** rtl/snf_feature_regs.sv ***
// snf_feature_regs: feature and status register bank of a serial nand flash
// assumes: array engine reports busy, fail and ecc results on same clock
// Function
// - sample rising edge, drive falling edge
// - get 0Fh and set 1Fh with address
// - settings persist through the reset command
// - lock register A0h, reset 38h
// - protect range decodes to locked row fraction
// - otp register B0h, reset 10h
// - ecc enable bit drives internal ecc
// - otp protect and enable decode
// - status register C0h bit layout
// - drive register D0h, reset 20h, strength decode
// - write enable 06h sets latch
// - write disable 04h clears latch
// - latch reads zero after power up
// - ecc result cleared on reset, read start
// - ecc result invalid when ecc off; status ecc field is reported whether or not the ecc enable bit is set
// - ecc result code meanings
// - program fail set on failure, cleared on execute
// - erase fail set on failure, cleared on erase
// - busy while operation executes
// - status readable while busy
// - no latch means sequence ignored
`timescale 1ns/100ps
module snf_feature_regs (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic sck_i,
   input wire logic csn_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   input wire logic array_busy_i,
   input wire logic prog_fail_i,
   input wire logic erase_fail_i,
   input wire logic read_done_i,
   input wire logic [1:0] ecc_result_i,
   output logic [7:0] cmd_o,
   output logic cmd_valid_o,
   output logic [1:0] protect_range_o,
   output logic [2:0] protect_code_o,
   output logic lock_reg_write_disable_o,
   output logic [6:0] locked_fraction_log2_o,
   output logic ecc_enable_o,
   output logic [1:0] otp_mode_o,
   output logic [1:0] drive_strength_o,
   output logic [6:0] drive_percent_o,
   output logic write_enable_latch_o,
   output logic busy_flag_o
);
   typedef enum logic [1:0] {SNF_IDLE, SNF_ADDR, SNF_DATA, SNF_SKIP} snf_state_e;
   typedef struct packed {
      snf_state_e fsm;
      logic [7:0] op;
      logic [7:0] addr;
      logic [7:0] lock;
      logic [7:0] otp;
      logic [7:0] drv;
      logic [1:0] ecc;
      logic pfail;
      logic efail;
      logic write_enable_latch;
      logic rst_busy;
      logic [7:0] cmd;
      logic cmd_v;
      logic [7:0] tx;
      logic txl;
   } snf_core_s;
   snf_core_s st_reg, st_next;
   snf_link_if lnk ();

   snf_link_rx u_link (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .sck_i(sck_i),
      .csn_i(csn_i),
      .si_i(si_i),
      .so_o(so_o),
      .so_oe_o(so_oe_o),
      .lnk(lnk)
   );

   function automatic logic [7:0] status_byte(input snf_core_s s, input logic busy);
      status_byte = 8'h00;
      status_byte[snf_pkg::ST_ECC_LSB +: 2] = s.ecc;
      status_byte[snf_pkg::ST_PFAIL_BIT] = s.pfail;
      status_byte[snf_pkg::ST_EFAIL_BIT] = s.efail;
      status_byte[snf_pkg::ST_WEL_BIT] = s.write_enable_latch;
      status_byte[snf_pkg::ST_BUSY_BIT] = busy;
   endfunction : status_byte

   function automatic logic [7:0] read_feature(input snf_core_s s, input logic [7:0] a, input logic busy);
      case (a) // reserved bits are masked to zero
         snf_pkg::ADDR_LOCK: read_feature = s.lock & snf_pkg::MASK_LOCK;
         snf_pkg::ADDR_OTP: read_feature = s.otp & snf_pkg::MASK_OTP;
         snf_pkg::ADDR_STATUS: read_feature = status_byte(s, busy);
         snf_pkg::ADDR_DRIVE: read_feature = s.drv & snf_pkg::MASK_DRIVE;
         default: read_feature = 8'h00;
      endcase
   endfunction : read_feature

   logic busy;
   assign busy = array_busy_i | st_reg.rst_busy;

   always_comb begin
      st_next = st_reg;
      st_next.cmd_v = 1'b0;
      st_next.txl = 1'b0;
      st_next.rst_busy = 1'b0;
      // fail flags set by the array; set wins over clear below
      if (lnk.frame_start) begin
         st_next.fsm = SNF_IDLE;
      end
      if (lnk.byte_valid) begin
         case (st_reg.fsm)
            SNF_IDLE: begin
               st_next.op = lnk.rx_byte;
               st_next.fsm = SNF_SKIP;
               case (lnk.rx_byte)
                  snf_pkg::OP_GET_FEATURE, snf_pkg::OP_SET_FEATURE: begin
                     st_next.fsm = SNF_ADDR;
                  end
                  snf_pkg::OP_WRITE_ENABLE: begin
                     st_next.write_enable_latch = 1'b1;
                  end
                  snf_pkg::OP_WRITE_DISABLE: begin
                     st_next.write_enable_latch = 1'b0;
                  end
                  snf_pkg::OP_RESET: begin
                     // feature registers untouched
                     st_next.ecc = 2'h0;
                     st_next.pfail = 1'b0;
                     st_next.efail = 1'b0;
                     st_next.rst_busy = 1'b1;
                     st_next.cmd = lnk.rx_byte;
                     st_next.cmd_v = 1'b1;
                  end
                  snf_pkg::OP_PROGRAM_EXEC: begin
                     // forwarded only with the latch set
                     if (st_reg.write_enable_latch) begin
                        st_next.pfail = 1'b0;
                        st_next.cmd = lnk.rx_byte;
                        st_next.cmd_v = 1'b1;
                     end
                  end
                  snf_pkg::OP_BLOCK_ERASE: begin
                     if (st_reg.write_enable_latch) begin
                        st_next.efail = 1'b0;
                        st_next.cmd = lnk.rx_byte;
                        st_next.cmd_v = 1'b1;
                     end
                  end
                  snf_pkg::OP_PAGE_READ: begin
                     st_next.ecc = 2'h0;
                     st_next.cmd = lnk.rx_byte;
                     st_next.cmd_v = 1'b1;
                  end
                  default: begin
                     st_next.cmd = lnk.rx_byte;
                     st_next.cmd_v = 1'b1;
                  end
               endcase
            end
            SNF_ADDR: begin
               st_next.addr = lnk.rx_byte;
               st_next.fsm = SNF_DATA;
               if (st_reg.op == snf_pkg::OP_GET_FEATURE) begin
                  st_next.tx = read_feature(st_reg, lnk.rx_byte, busy);
                  st_next.txl = 1'b1;
               end
            end
            SNF_DATA: begin
               if (st_reg.op == snf_pkg::OP_SET_FEATURE) begin
                  case (st_reg.addr)
                     snf_pkg::ADDR_LOCK: begin
                        if (!st_reg.lock[snf_pkg::LOCK_WD_BIT]) begin
                           st_next.lock = lnk.rx_byte & snf_pkg::MASK_LOCK;
                        end
                     end
                     snf_pkg::ADDR_OTP: st_next.otp = lnk.rx_byte & snf_pkg::MASK_OTP;
                     snf_pkg::ADDR_DRIVE: st_next.drv = lnk.rx_byte & snf_pkg::MASK_DRIVE;
                     default: st_next.fsm = SNF_SKIP; // status is read only
                  endcase
                  st_next.fsm = SNF_SKIP;
               end else begin
                  // repeat status while polling
                  st_next.tx = read_feature(st_reg, st_reg.addr, busy);
                  st_next.txl = 1'b1;
               end
            end
            SNF_SKIP: st_next.fsm = SNF_SKIP;
            default: st_next.fsm = SNF_IDLE;
         endcase
      end
      if (read_done_i) begin
         st_next.ecc = ecc_result_i;
      end
      if (prog_fail_i) begin
         st_next.pfail = 1'b1;
      end
      if (erase_fail_i) begin
         st_next.efail = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
         st_reg.lock <= snf_pkg::RST_LOCK;
         st_reg.otp <= snf_pkg::RST_OTP;
         st_reg.drv <= snf_pkg::RST_DRIVE;
         st_reg.write_enable_latch <= 1'b0;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign lnk.tx_byte = st_reg.tx;
   assign lnk.tx_load = st_reg.txl;

   always_comb begin
      case (st_reg.lock[snf_pkg::LOCK_BP_LSB +: 3])
         3'h0: locked_fraction_log2_o = 7'h00;
         3'h1: locked_fraction_log2_o = 7'h06;
         3'h2: locked_fraction_log2_o = 7'h05;
         3'h3: locked_fraction_log2_o = 7'h04;
         3'h4: locked_fraction_log2_o = 7'h03;
         3'h5: locked_fraction_log2_o = 7'h02;
         3'h6: locked_fraction_log2_o = 7'h01;
         default: locked_fraction_log2_o = 7'h7F;
      endcase
      case (st_reg.drv[snf_pkg::DRV_LSB +: 2])
         2'h0: drive_percent_o = 7'h64;
         2'h1: drive_percent_o = 7'h4B;
         2'h2: drive_percent_o = 7'h32;
         default: drive_percent_o = 7'h19;
      endcase
   end

   assign protect_code_o = st_reg.lock[snf_pkg::LOCK_BP_LSB +: 3];
   assign protect_range_o = {st_reg.lock[snf_pkg::LOCK_BP_LSB +: 3] == 3'h7, st_reg.lock[snf_pkg::LOCK_BP_LSB +: 3] != 3'h0};
   assign lock_reg_write_disable_o = st_reg.lock[snf_pkg::LOCK_WD_BIT];
   assign ecc_enable_o = st_reg.otp[snf_pkg::OTP_ECC_BIT];
   assign otp_mode_o = {st_reg.otp[snf_pkg::OTP_PROT_BIT], st_reg.otp[snf_pkg::OTP_EN_BIT]};
   assign drive_strength_o = st_reg.drv[snf_pkg::DRV_LSB +: 2];
   assign write_enable_latch_o = st_reg.write_enable_latch;
   assign busy_flag_o = busy;
   assign cmd_o = st_reg.cmd;
   assign cmd_valid_o = st_reg.cmd_v;

   chk_wel_set_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ce_i && lnk.byte_valid && st_reg.fsm == SNF_IDLE && lnk.rx_byte == snf_pkg::OP_WRITE_ENABLE
      |=> st_reg.write_enable_latch) else $error("latch not set by write enable");
   chk_wel_clr_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ce_i && lnk.byte_valid && st_reg.fsm == SNF_IDLE && lnk.rx_byte == snf_pkg::OP_WRITE_DISABLE
      |=> !st_reg.write_enable_latch) else $error("latch not cleared by write disable");
   chk_pfail_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ce_i && prog_fail_i |=> st_reg.pfail) else $error("program fail lost");
   chk_efail_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ce_i && erase_fail_i |=> st_reg.efail) else $error("erase fail lost");
   chk_busy_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
      array_busy_i |-> busy_flag_o) else $error("busy flag not raised");
   chk_reset_busy: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ce_i && lnk.byte_valid && st_reg.fsm == SNF_IDLE && lnk.rx_byte == snf_pkg::OP_RESET
      |=> busy_flag_o) else $error("busy flag not raised by reset command");
   chk_no_wel_drop: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_valid_o && (cmd_o == snf_pkg::OP_BLOCK_ERASE || cmd_o == snf_pkg::OP_PROGRAM_EXEC)
      |-> $past(st_reg.write_enable_latch)) else $error("program or erase forwarded without latch");
   chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (st_reg.lock & ~snf_pkg::MASK_LOCK) == 8'h00 && (st_reg.drv & ~snf_pkg::MASK_DRIVE) == 8'h00)
      else $error("reserved bit set");
   chk_reset_keeps: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ce_i && lnk.byte_valid && st_reg.fsm == SNF_IDLE && lnk.rx_byte == snf_pkg::OP_RESET
      |=> $stable(st_reg.otp) && st_reg.ecc == 2'h0) else $error("reset command altered settings");
endmodule : snf_feature_regs

// *** rtl/snf_pkg.sv ***
// snf_pkg: shared constants for the serial flash feature and status register block
// assumes: included before every other design file
package snf_pkg;
   // link opcodes
   localparam logic [7:0] OP_GET_FEATURE = 8'h0F;
   localparam logic [7:0] OP_SET_FEATURE = 8'h1F;
   localparam logic [7:0] OP_RESET = 8'hFF;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_PROGRAM_EXEC = 8'h10;
   localparam logic [7:0] OP_PAGE_READ = 8'h13;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
   // feature addresses
   localparam logic [7:0] ADDR_LOCK = 8'hA0;
   localparam logic [7:0] ADDR_OTP = 8'hB0;
   localparam logic [7:0] ADDR_STATUS = 8'hC0;
   localparam logic [7:0] ADDR_DRIVE = 8'hD0;
   // reset values
   localparam logic [7:0] RST_LOCK = 8'h38;
   localparam logic [7:0] RST_OTP = 8'h10;
   localparam logic [7:0] RST_DRIVE = 8'h20;
   // writable masks, reserved bits read zero
   localparam logic [7:0] MASK_LOCK = 8'hB8;
   localparam logic [7:0] MASK_OTP = 8'hD0;
   localparam logic [7:0] MASK_DRIVE = 8'h60;
   // field positions
   localparam int LOCK_WD_BIT = 7;
   localparam int LOCK_BP_LSB = 3;
   localparam int OTP_PROT_BIT = 7;
   localparam int OTP_EN_BIT = 6;
   localparam int OTP_ECC_BIT = 4;
   localparam int DRV_LSB = 5;
   localparam int ST_ECC_LSB = 4;
   localparam int ST_PFAIL_BIT = 3;
   localparam int ST_EFAIL_BIT = 2;
   localparam int ST_WEL_BIT = 1;
   localparam int ST_BUSY_BIT = 0;
   // otp mode codes
   typedef enum logic [1:0] {SNF_OTP_NORMAL, SNF_OTP_ACCESS, SNF_OTP_NA, SNF_OTP_LOCKED} snf_otp_e;
   localparam int SYNC_STAGES = 2;
endpackage : snf_pkg

// *** rtl/snf_link_if.sv ***
// snf_link_if: byte stream between the link front end and the register core
// assumes: one clock domain, clk_i of the top
`timescale 1ns/100ps
interface snf_link_if;
   logic frame_start;
   logic byte_valid;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic tx_load;
   logic frame_end;
   modport front (output frame_start, output byte_valid, output rx_byte, output frame_end,
                  input tx_byte, input tx_load);
   modport core (input frame_start, input byte_valid, input rx_byte, input frame_end,
                 output tx_byte, output tx_load);
endinterface : snf_link_if

// *** rtl/snf_link_rx.sv ***
// snf_link_rx: samples the serial pins, finds clock edges, shifts bytes in and out
// assumes: link clock far slower than clk_i; pins are asynchronous
`timescale 1ns/100ps
module snf_link_rx (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic sck_i,
   input wire logic csn_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   snf_link_if.front lnk
);
   typedef struct packed {
      logic [1:0] sck_s;
      logic [1:0] csn_s;
      logic [1:0] si_s;
      logic sck_d;
      logic csn_d;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic so;
      logic oe;
      logic bv;
      logic fs;
      logic fe;
   } snf_rx_s;
   snf_rx_s st_reg, st_next;
   logic rise, fall;

   always_comb begin
      st_next = st_reg;
      st_next.sck_s = {st_reg.sck_s[0], sck_i};
      st_next.csn_s = {st_reg.csn_s[0], csn_i};
      st_next.si_s = {st_reg.si_s[0], si_i};
      st_next.sck_d = st_reg.sck_s[1];
      st_next.csn_d = st_reg.csn_s[1];
      st_next.bv = 1'b0;
      st_next.fs = st_reg.csn_d & ~st_reg.csn_s[1];
      st_next.fe = ~st_reg.csn_d & st_reg.csn_s[1];
      rise = ~st_reg.sck_d & st_reg.sck_s[1];
      fall = st_reg.sck_d & ~st_reg.sck_s[1];
      if (st_reg.csn_s[1]) begin
         st_next.cnt = 3'h0;
         st_next.oe = 1'b0;
      end else begin
         if (rise) begin // sample on rising edge in both modes
            st_next.sh = {st_reg.sh[6:0], st_reg.si_s[1]};
            st_next.cnt = st_reg.cnt + 3'h1;
            if (st_reg.cnt == 3'h7) begin
               st_next.bv = 1'b1;
            end
         end
         if (lnk.tx_load) begin
            st_next.tx = lnk.tx_byte;
         end
         if (fall) begin // drive from falling edge
            st_next.so = st_reg.tx[7];
            st_next.tx = {st_reg.tx[6:0], 1'b0};
         end
      end
      if (st_next.bv) begin
         st_next.oe = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
         st_reg.csn_s <= 2'h3;
         st_reg.csn_d <= 1'b1;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // idle clock level is set by the host between frames
   assign lnk.frame_start = st_reg.fs;
   assign lnk.frame_end = st_reg.fe;
   assign lnk.byte_valid = st_reg.bv;
   assign lnk.rx_byte = st_reg.sh;
   assign so_o = st_reg.so;
   assign so_oe_o = st_reg.oe;
endmodule : snf_link_rx

// *** tb/snf_host_model.sv ***
// snf_host_model: serial host that frames opcodes, addresses and data to the flash feature block
// assumes: clk_i is the bench clock; one link bit spans 8 cycles of it (400 ns)
`timescale 1ns/100ps
module snf_host_model (
   input wire logic clk_i,
   output logic sck_o,
   output logic csn_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   initial begin
      sck_o = 1'b0;
      csn_o = 1'b1;
      si_o = 1'b1;
   end
   // sends n bytes msb first, returns the last byte seen on so
   task automatic xfer(input logic mode3, input logic [7:0] b0, b1, b2, b3, input int n, output logic [7:0] rx);
      logic [31:0] word;
      word = {b0, b1, b2, b3};
      rx = 8'h00;
      @(posedge clk_i);
      sck_o <= mode3;
      repeat (8) @(posedge clk_i);
      csn_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         for (int k = 7; k >= 0; k--) begin
            sck_o <= 1'b0;
            si_o <= word[31 - 8 * i - (7 - k)];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            // output stands until the next falling edge, so it is read at the end of the high phase
            rx = {rx[6:0], so_oe_i === 1'b1 ? so_i : 1'bx};
         end
      end
      sck_o <= mode3;
      repeat (4) @(posedge clk_i);
      csn_o <= 1'b1;
      si_o <= ~si_o;
      repeat (8) @(posedge clk_i);
   endtask : xfer
endmodule : snf_host_model

// *** tb/tb.sv ***
// tb: self-checking bench for the feature and status register block
// assumes: snf_host_model drives the link pins; array engine signals come from the bench
`timescale 1ns/100ps
module tb;
   logic clk_i, rstn_i, sck, csn, si, so, so_oe, cmd_valid_o, lwd, ecc_en, write_enable_latch, busy, md;
   logic array_busy_i, prog_fail_i, erase_fail_i, read_done_i;
   logic [1:0] ecc_result_i, prange, otp_mode, drv;
   logic [2:0] pcode;
   logic [6:0] frac, pct;
   logic [7:0] cmd_o, rd, d, last_cmd;
   logic [31:0] seed, r;
   int failures, check_count, cycles, pulses, busy_cycles;
   int m_lock, m_otp, m_drv, m_wel, m_pf, m_ef, m_ecc, m_busy;
   int fr[8] = '{0, 6, 5, 4, 3, 2, 1, 127};
   int pc[4] = '{100, 75, 50, 25};

   snf_feature_regs i_snf_feature_regs (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .sck_i(sck), .csn_i(csn),
      .si_i(si), .so_o(so), .so_oe_o(so_oe), .array_busy_i(array_busy_i), .prog_fail_i(prog_fail_i),
      .erase_fail_i(erase_fail_i), .read_done_i(read_done_i), .ecc_result_i(ecc_result_i), .cmd_o(cmd_o),
      .cmd_valid_o(cmd_valid_o), .protect_range_o(prange), .protect_code_o(pcode),
      .lock_reg_write_disable_o(lwd), .locked_fraction_log2_o(frac), .ecc_enable_o(ecc_en),
      .otp_mode_o(otp_mode), .drive_strength_o(drv), .drive_percent_o(pct), .write_enable_latch_o(write_enable_latch),
      .busy_flag_o(busy));
   snf_host_model i_snf_host_model (.clk_i(clk_i), .sck_o(sck), .csn_o(csn), .si_o(si), .so_i(so), .so_oe_i(so_oe));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cmd_valid_o === 1'b1) begin
         pulses++;
         last_cmd = cmd_o;
      end
      if (busy === 1'b1 && array_busy_i === 1'b0) busy_cycles++;
      if (cycles == 30000) begin
         failures++;
         final_report();
      end
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function logic [7:0] st();
      return 8'(m_ecc * 16 + m_pf * 8 + m_ef * 4 + m_wel * 2 + m_busy);
   endfunction : st
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic xf(input logic [7:0] b0, b1, b2, b3, input int n);
      i_snf_host_model.xfer(md, b0, b1, b2, b3, n, rd);
   endtask : xf
   task automatic get_chk(input logic [7:0] a, input int exp);
      xf(snf_pkg::OP_GET_FEATURE, a, 8'h00, 8'h00, 3);
      check("feature", 8'(exp), rd);
   endtask : get_chk
   task automatic set(input logic [7:0] a, dd);
      xf(snf_pkg::OP_SET_FEATURE, a, dd, 8'h00, 3);
   endtask : set
   // one-cycle result pulses from the array engine
   task automatic flags(input int e);
      @(posedge clk_i);
      prog_fail_i <= 1'b1;
      erase_fail_i <= 1'b1;
      read_done_i <= 1'b1;
      ecc_result_i <= 2'(e);
      @(posedge clk_i);
      prog_fail_i <= 1'b0;
      erase_fail_i <= 1'b0;
      read_done_i <= 1'b0;
      m_pf = 1;
      m_ef = 1;
      m_ecc = e;
   endtask : flags
   task automatic final_report();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   initial begin
      rstn_i = 1'b0;
      array_busy_i = 1'b0;
      prog_fail_i = 1'b0;
      erase_fail_i = 1'b0;
      read_done_i = 1'b0;
      ecc_result_i = 2'h0;
      seed = 32'h0000004A;
      md = 1'b0;
      m_lock = 'h38;
      m_otp = 'h10;
      m_drv = 'h20;
      repeat (4) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      get_chk(snf_pkg::ADDR_LOCK, m_lock);
      get_chk(snf_pkg::ADDR_OTP, m_otp);
      get_chk(snf_pkg::ADDR_DRIVE, m_drv);
      xf(snf_pkg::OP_GET_FEATURE, snf_pkg::ADDR_STATUS, 8'h00, 8'h00, 3);
      check("latch", 8'h00, rd & 8'h03);
      check("fields", 8'hEA, {pcode, lwd, ecc_en, drv, write_enable_latch});
      check("fraction", 8'h7F, {1'b0, frac});
      $display("test reset values done");
      for (int c = 0; c < 8; c++) begin
         r = rnd();
         md = r[8];
         d = {1'b0, r[6], 3'(c), r[2:0]};
         set(snf_pkg::ADDR_LOCK, d);
         m_lock = d & 8'h38;
         get_chk(snf_pkg::ADDR_LOCK, m_lock);
         check("fraction", 8'(fr[c]), {1'b0, frac});
         check("range", 8'({c == 7, c != 0, 3'(c)}), {3'h0, prange, pcode});
         d = {r[7], 2'(c), r[4:0]};
         set(snf_pkg::ADDR_DRIVE, d);
         m_drv = d & 8'h60;
         get_chk(snf_pkg::ADDR_DRIVE, m_drv);
         check("percent", 8'(pc[c % 4]), {1'b0, pct});
         check("strength", 8'(c % 4), {6'h00, drv});
         d = {2'(c), r[5:0]};
         set(snf_pkg::ADDR_OTP, d);
         m_otp = d & 8'hD0;
         get_chk(snf_pkg::ADDR_OTP, m_otp);
         check("otp mode", 8'((c % 4) * 2 + d[4]), {5'h00, otp_mode, ecc_en});
      end
      set(snf_pkg::ADDR_OTP, 8'h10);
      $display("test feature registers done");
      for (int e = 0; e < 3; e++) begin
         flags(e);
         get_chk(snf_pkg::ADDR_STATUS, st());
      end
      set(snf_pkg::ADDR_STATUS, 8'hFF);
      set(8'h90, 8'hFF);
      get_chk(snf_pkg::ADDR_STATUS, st());
      get_chk(snf_pkg::ADDR_LOCK, m_lock);
      xf(snf_pkg::OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 1);
      m_wel = 1;
      get_chk(snf_pkg::ADDR_STATUS, st());
      xf(snf_pkg::OP_WRITE_DISABLE, 8'h00, 8'h00, 8'h00, 1);
      m_wel = 0;
      get_chk(snf_pkg::ADDR_STATUS, st());
      $display("test status and latch done");
      pulses = 0;
      xf(snf_pkg::OP_PROGRAM_EXEC, 8'h00, r[15:8], r[7:0], 4);
      xf(snf_pkg::OP_BLOCK_ERASE, 8'h00, r[23:16], r[7:0], 4);
      check("ignored", 8'h00, 8'(pulses));
      get_chk(snf_pkg::ADDR_STATUS, st());
      xf(snf_pkg::OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 1);
      xf(snf_pkg::OP_PROGRAM_EXEC, 8'h00, r[15:8], r[7:0], 4);
      m_pf = 0;
      check("program", snf_pkg::OP_PROGRAM_EXEC, last_cmd);
      xf(snf_pkg::OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 1);
      xf(snf_pkg::OP_BLOCK_ERASE, 8'h00, r[23:16], r[7:0], 4);
      m_ef = 0;
      check("erase", snf_pkg::OP_BLOCK_ERASE, last_cmd);
      check("forwarded", 8'h02, 8'(pulses));
      xf(snf_pkg::OP_WRITE_DISABLE, 8'h00, 8'h00, 8'h00, 1);
      get_chk(snf_pkg::ADDR_STATUS, st());
      $display("test program and erase done");
      flags(1);
      busy_cycles = 0;
      xf(snf_pkg::OP_RESET, 8'h00, 8'h00, 8'h00, 1);
      m_pf = 0;
      m_ef = 0;
      m_ecc = 0;
      check("reset busy", 8'h01, 8'(busy_cycles));
      get_chk(snf_pkg::ADDR_STATUS, st());
      get_chk(snf_pkg::ADDR_LOCK, m_lock);
      get_chk(snf_pkg::ADDR_DRIVE, m_drv);
      @(posedge clk_i);
      array_busy_i <= 1'b1;
      m_busy = 1;
      get_chk(snf_pkg::ADDR_STATUS, st());
      check("busy", 8'h01, {7'h00, busy});
      @(posedge clk_i);
      array_busy_i <= 1'b0;
      m_busy = 0;
      $display("test reset command and busy done");
      m_lock = m_lock | 'h80;
      set(snf_pkg::ADDR_LOCK, 8'(m_lock));
      set(snf_pkg::ADDR_LOCK, 8'h00);
      get_chk(snf_pkg::ADDR_LOCK, m_lock);
      check("write disable", 8'h01, {7'h00, lwd});
      $display("test lock write disable done");
      final_report();
   end
endmodule : tb
